// ==== mwu_device.sv ====
`timescale 1ns/10ps
module mwu_device
  import mwu_pkg::*;
#(
  parameter int READY_CYCLES = READY_CYC,
  parameter int SETTLE_CYCLES = SETTLE_CYC,
  parameter int RATE_TOP_CYCLES = RATE_TOP_CYC
) (
  input wire logic ref_clk, // 10 MHz clock
  input wire logic rst_n, // Synchronous reset
  mwu_link_if.dev link, // Serial bus and interrupt pin
  input wire logic sample_valid, // New three-axis sample
  input wire logic [2:0][SAMPLE_W-1:0] sample_xyz, // Two's complement, [2]=x [1]=y [0]=z
  output logic outputs_valid // Acceleration outputs settled
);

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_d;
    logic sda_d;
    mwu_slv_e st;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic ack_ok;
    logic sda_oe;
    logic [7:0] pwr;
    logic [7:0] rate;
    logic [7:0] pin;
    logic [7:0] mask;
    logic [7:0] persist;
    logic [7:0] thr;
    logic [19:0] ready_cnt;
    logic ready;
    logic [19:0] settle_cnt;
    logic valid_out;
    logic [23:0] rate_cnt;
    logic tick_pend;
    logic [2:0][SAMPLE_W-1:0] prev;
    logic prev_ok;
    logic [7:0] run;
    logic latched;
    logic [8:0] pulse_cnt;
    logic int_pin;
  } mwu_dev_s;

  mwu_dev_s s;
  mwu_dev_s next_s;
  logic [5:0] hit;
  logic [14:0] thr_ext;

  assign thr_ext = {1'b0, s.thr, 6'b00_0000};

  // Axis a: bit 2a is the positive direction, bit 2a+1 the negative one
  for (genvar a = 0; a < 3; a++) begin : g_axis
    logic signed [14:0] diff;
    assign diff = $signed({{3{sample_xyz[a][SAMPLE_W-1]}}, sample_xyz[a]})
                - $signed({{3{s.prev[a][SAMPLE_W-1]}}, s.prev[a]});
    assign hit[2*a] = diff > $signed(thr_ext);
    assign hit[2*a+1] = diff < -$signed(thr_ext);
  end

  function automatic logic [7:0] read_reg(input mwu_dev_s r, input logic [7:0] a);
    logic [7:0] v;
    v = READ_UNMAPPED;
    unique case (a)
      REG_INT_RELEASE: v = {7'h00, r.latched};
      REG_POWER_MODE: v = r.pwr;
      REG_RATE_CTRL: v = r.rate;
      REG_PIN_CONFIG: v = r.pin;
      REG_DIR_MASK: v = r.mask;
      REG_PERSIST: v = r.persist;
      REG_THRESHOLD: v = r.thr;
      default: v = READ_UNMAPPED;
    endcase
    return v;
  endfunction

  logic scl;
  logic sda;
  logic start_ev;
  logic stop_ev;
  logic rise;
  logic fall;
  logic rel_read;
  logic detect;
  logic motion;
  logic armed;
  logic [23:0] period;
  logic [7:0] run_inc;
  logic [7:0] rd_byte;

  always_comb begin
    next_s = s;
    scl = s.scl_sync[1];
    sda = s.sda_sync[1];
    next_s.scl_sync = {s.scl_sync[0], link.scl};
    next_s.sda_sync = {s.sda_sync[0], link.sda};
    next_s.scl_d = scl;
    next_s.sda_d = sda;
    start_ev = scl && s.scl_d && s.sda_d && !sda;
    stop_ev = scl && s.scl_d && !s.sda_d && sda;
    rise = scl && !s.scl_d;
    fall = !scl && s.scl_d;
    rel_read = 1'b0;
    rd_byte = read_reg(s, s.ptr);

    // Bus stays deaf until the start-up delay has run out
    if (!s.ready) begin
      next_s.ready_cnt = s.ready_cnt + 20'h0_0001;
      next_s.ready = s.ready_cnt == 20'(READY_CYCLES - 1);
    end

    // Oversampled slave: fast-mode at most, high-speed rates are not reachable here
    if (start_ev) begin
      next_s.st = SL_ADDR;
      next_s.bitc = 4'h0;
      next_s.sda_oe = 1'b0;
    end else if (stop_ev) begin
      next_s.st = SL_IDLE;
      next_s.sda_oe = 1'b0;
    end else if (rise) begin
      unique case (s.st)
        SL_ADDR, SL_REG, SL_WR: begin
          next_s.sh = {s.sh[6:0], sda};
          next_s.bitc = s.bitc + 4'h1;
        end
        SL_RD: next_s.bitc = s.bitc + 4'h1;
        SL_RD_ACK: next_s.ack_ok = !sda;
        default: ;
      endcase
    end else if (fall) begin
      unique case (s.st)
        SL_IDLE: ;
        SL_ADDR: if (s.bitc == 4'h8) begin
          if (s.sh[7:1] == DEV_ADDR && s.ready) begin
            next_s.st = SL_ADDR_ACK;
            next_s.rw = s.sh[0];
            next_s.sda_oe = 1'b1;
          end else begin
            next_s.st = SL_IDLE;
          end
        end
        SL_ADDR_ACK, SL_RD_ACK: begin
          next_s.bitc = 4'h0;
          if (s.st == SL_ADDR_ACK && !s.rw) begin
            next_s.st = SL_REG;
            next_s.sda_oe = 1'b0;
          end else if (s.st == SL_ADDR_ACK || s.ack_ok) begin
            next_s.st = SL_RD;
            next_s.sh = rd_byte;
            next_s.sda_oe = !rd_byte[7];
            next_s.ptr = s.ptr + 8'h01;
            rel_read = s.ptr == REG_INT_RELEASE;
          end else begin
            next_s.st = SL_IDLE;
            next_s.sda_oe = 1'b0;
          end
        end
        SL_REG: if (s.bitc == 4'h8) begin
          next_s.ptr = s.sh;
          next_s.st = SL_REG_ACK;
          next_s.sda_oe = 1'b1;
        end
        SL_REG_ACK, SL_WR_ACK: begin
          next_s.st = SL_WR;
          next_s.bitc = 4'h0;
          next_s.sda_oe = 1'b0;
        end
        SL_WR: if (s.bitc == 4'h8) begin
          unique case (s.ptr)
            REG_POWER_MODE: next_s.pwr = s.sh;
            REG_RATE_CTRL: next_s.rate = s.sh;
            REG_PIN_CONFIG: next_s.pin = s.sh;
            REG_DIR_MASK: next_s.mask = s.sh;
            REG_PERSIST: next_s.persist = s.sh;
            REG_THRESHOLD: next_s.thr = s.sh;
            default: ;
          endcase
          next_s.ptr = s.ptr + 8'h01;
          next_s.st = SL_WR_ACK;
          next_s.sda_oe = 1'b1;
        end
        SL_RD: begin
          if (s.bitc == 4'h8) begin
            next_s.st = SL_RD_ACK;
            next_s.sda_oe = 1'b0;
          end else begin
            next_s.sh = {s.sh[6:0], 1'b0};
            next_s.sda_oe = !s.sh[6];
          end
        end
        default: next_s.st = SL_IDLE;
      endcase
    end

    // Settling after the operate bit; restarts on every standby
    if (!s.pwr[OPERATE_BIT]) begin
      next_s.settle_cnt = 20'h0_0000;
      next_s.valid_out = 1'b0;
    end else if (!s.valid_out) begin
      next_s.settle_cnt = s.settle_cnt + 20'h0_0001;
      next_s.valid_out = s.settle_cnt == 20'(SETTLE_CYCLES - 1);
    end

    armed = s.pwr[OPERATE_BIT] && s.pwr[WAKE_EN_BIT] && s.valid_out;
    period = 24'(RATE_TOP_CYCLES) << (RATE_TOP_CODE - s.rate[RATE_LSB +: RATE_W]);
    if (!armed) begin
      next_s.rate_cnt = 24'h00_0000;
      next_s.tick_pend = 1'b0;
      next_s.prev_ok = 1'b0;
      next_s.run = 8'h00;
    end else if (s.rate_cnt == period - 24'h00_0001) begin
      next_s.rate_cnt = 24'h00_0000;
      next_s.tick_pend = 1'b1;
    end else begin
      next_s.rate_cnt = s.rate_cnt + 24'h00_0001;
    end

    motion = |(hit & s.mask[5:0]);
    run_inc = (s.run == 8'hFF) ? s.run : s.run + 8'h01;
    detect = 1'b0;
    // One sample is taken per motion tick; the first only seeds the reference
    if (armed && s.tick_pend && sample_valid) begin
      next_s.tick_pend = 1'b0;
      next_s.prev = sample_xyz;
      next_s.prev_ok = 1'b1;
      if (s.prev_ok && motion) begin
        next_s.run = run_inc;
        detect = run_inc >= s.persist;
      end else begin
        next_s.run = 8'h00;
      end
    end

    // A detection in the clearing cycle wins over the release read
    next_s.latched = detect || (s.latched && !rel_read);
    if (detect && s.pulse_cnt == 9'h000) begin
      next_s.pulse_cnt = 9'(PULSE_CYC);
    end else if (s.pulse_cnt != 9'h000) begin
      next_s.pulse_cnt = s.pulse_cnt - 9'h001;
    end
    if (!s.pin[PIN_EN_BIT]) begin
      next_s.int_pin = !s.pin[PIN_POL_BIT];
    end else if (s.pin[PIN_PULSE_BIT]) begin
      next_s.int_pin = (s.pulse_cnt != 9'h000) ~^ s.pin[PIN_POL_BIT];
    end else begin
      next_s.int_pin = next_s.latched ~^ s.pin[PIN_POL_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link.sda_o_dev = 1'b0;
  assign link.sda_oe_dev = s.sda_oe;
  assign link.int_pin = s.int_pin;
  assign outputs_valid = s.valid_out;

endmodule

// ==== mwu_pkg.sv ====
package mwu_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_PER_US = CLK_HZ / 1_000_000;

  // Bus address of the device; value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h0E;

  localparam logic [7:0] REG_INT_RELEASE = 8'h1A;
  localparam logic [7:0] REG_POWER_MODE = 8'h1B;
  localparam logic [7:0] REG_RATE_CTRL = 8'h1D;
  localparam logic [7:0] REG_PIN_CONFIG = 8'h1E;
  localparam logic [7:0] REG_DIR_MASK = 8'h1F;
  localparam logic [7:0] REG_PERSIST = 8'h29;
  localparam logic [7:0] REG_THRESHOLD = 8'h6A;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  localparam int OPERATE_BIT = 7;
  localparam int WAKE_EN_BIT = 1;
  localparam int PIN_EN_BIT = 5;
  localparam int PIN_POL_BIT = 4;
  localparam int PIN_PULSE_BIT = 3;
  localparam int RATE_LSB = 0;
  localparam int RATE_W = 3;
  localparam logic [2:0] RATE_TOP_CODE = 3'h7;

  // 12-bit samples at +/-2g: 1024 counts per g, threshold step is g/16
  localparam int SAMPLE_W = 12;
  localparam int THR_PER_G = 16;
  localparam int THR_SHIFT = 6;

  localparam int POR_READY_US = 10_000;
  localparam int SETTLE_MIN_US = 2_100;
  localparam int SETTLE_MAX_US = 80_000;
  localparam int PULSE_NS = 30_000;
  localparam int RATE_TOP_HZ = 100;
  localparam int I2C_FAST_HZ = 400_000;

  localparam int READY_CYC = POR_READY_US * CLK_PER_US;
  localparam int SETTLE_CYC = SETTLE_MIN_US * CLK_PER_US;
  localparam int PULSE_CYC = (PULSE_NS * CLK_PER_US + 999) / 1000;
  localparam int RATE_TOP_CYC = CLK_HZ / RATE_TOP_HZ;
  localparam int I2C_QTR_CYC = (CLK_HZ + 4 * I2C_FAST_HZ - 1) / (4 * I2C_FAST_HZ);

  typedef enum logic [3:0] {
    SL_IDLE = 4'h0,
    SL_ADDR = 4'h1,
    SL_ADDR_ACK = 4'h2,
    SL_REG = 4'h3,
    SL_REG_ACK = 4'h4,
    SL_WR = 4'h5,
    SL_WR_ACK = 4'h6,
    SL_RD = 4'h7,
    SL_RD_ACK = 4'h8
  } mwu_slv_e;

  typedef enum logic [1:0] {
    MS_IDLE = 2'h0,
    MS_START = 2'h1,
    MS_BIT = 2'h2,
    MS_STOP = 2'h3
  } mwu_mst_e;
endpackage

// ==== mwu_link_if.sv ====
`timescale 1ns/10ps
interface mwu_link_if;
  logic scl_o_host;
  logic scl_oe_host;
  logic sda_o_host;
  logic sda_oe_host;
  logic sda_o_dev;
  logic sda_oe_dev;
  logic int_pin;
  logic scl;
  logic sda;

  // Open-drain wires with pull-ups: low when any enabled driver drives low
  assign scl = ~(scl_oe_host & ~scl_o_host);
  assign sda = ~((sda_oe_host & ~sda_o_host) | (sda_oe_dev & ~sda_o_dev));

  modport dev (
    input scl,
    input sda,
    output sda_o_dev,
    output sda_oe_dev,
    output int_pin
  );

  modport host (
    input scl,
    input sda,
    input int_pin,
    output scl_o_host,
    output scl_oe_host,
    output sda_o_host,
    output sda_oe_host
  );
endinterface

// ==== mwu_host.sv ====
`timescale 1ns/10ps
module mwu_host
  import mwu_pkg::*;
#(
  parameter int READY_CYCLES = READY_CYC
) (
  input wire logic ref_clk, // 10 MHz clock
  input wire logic rst_n, // Synchronous reset
  mwu_link_if.host link, // Serial bus and interrupt pin
  input wire logic cmd_valid, // Register access request
  input wire logic cmd_read, // 1 read, 0 write
  input wire logic [7:0] cmd_reg, // Register address
  input wire logic [7:0] cmd_wdata, // Write data
  output logic cmd_ready, // Request may be taken
  output logic rsp_valid, // Access finished, one cycle
  output logic [7:0] rsp_data, // Read data
  output logic rsp_err, // No acknowledge, or refused
  output logic int_seen // Interrupt pin level, synchronised
);

  typedef struct packed {
    logic [1:0] sda_sync;
    logic [1:0] int_sync;
    mwu_mst_e st;
    logic [2:0] qc;
    logic [1:0] q;
    logic [3:0] bitc;
    logic [1:0] step;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic nack;
    logic scl_oe;
    logic sda_oe;
    logic [19:0] wait_cnt;
    logic ready;
    logic operate;
    logic cmd_ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_err;
    logic int_seen;
  } mwu_hst_s;

  mwu_hst_s s;
  mwu_hst_s next_s;
  logic sda;
  logic tick;
  logic settings_reg;

  always_comb begin
    next_s = s;
    sda = s.sda_sync[1];
    next_s.sda_sync = {s.sda_sync[0], link.sda};
    next_s.int_sync = {s.int_sync[0], link.int_pin};
    next_s.int_seen = s.int_sync[1];
    next_s.rsp_valid = 1'b0;
    if (!s.ready) begin
      next_s.wait_cnt = s.wait_cnt + 20'h0_0001;
      next_s.ready = s.wait_cnt == 20'(READY_CYCLES - 1);
    end
    tick = s.qc == 3'(I2C_QTR_CYC - 1);
    settings_reg = cmd_reg != REG_POWER_MODE && cmd_reg != REG_INT_RELEASE;

    if (s.st == MS_IDLE) begin
      next_s.qc = 3'h0;
      next_s.q = 2'h0;
      if (cmd_valid && s.cmd_ready) begin
        if (!cmd_read && s.operate && settings_reg) begin
          next_s.rsp_valid = 1'b1;
          next_s.rsp_err = 1'b1;
          next_s.rsp_data = 8'h00;
        end else begin
          // Threshold bytes pass through untouched, in sixteenths of g
          next_s.st = MS_START;
          next_s.rd = cmd_read;
          next_s.addr = cmd_reg;
          next_s.wdata = cmd_wdata;
          next_s.step = 2'h0;
          next_s.nack = 1'b0;
          next_s.tx = {DEV_ADDR, 1'b0};
        end
      end
    end else begin
      next_s.qc = tick ? 3'h0 : s.qc + 3'h1;
      if (tick) begin
        next_s.q = s.q + 2'h1;
        unique case (s.st)
          MS_START: begin
            unique case (s.q)
              2'h0: next_s.sda_oe = 1'b0;
              2'h1: next_s.scl_oe = 1'b0;
              2'h2: next_s.sda_oe = 1'b1;
              2'h3: begin
                next_s.scl_oe = 1'b1;
                next_s.st = MS_BIT;
                next_s.bitc = 4'h0;
              end
            endcase
          end
          MS_BIT: begin
            unique case (s.q)
              2'h0: next_s.sda_oe = (s.bitc < 4'h8) ? !s.tx[7] : 1'b0;
              2'h1: next_s.scl_oe = 1'b0;
              2'h2: begin
                if (s.bitc < 4'h8) begin
                  next_s.rx = {s.rx[6:0], sda};
                end else if (s.step != 2'h3) begin
                  next_s.nack = s.nack | sda;
                end
              end
              2'h3: begin
                next_s.scl_oe = 1'b1;
                next_s.tx = {s.tx[6:0], 1'b1};
                next_s.bitc = s.bitc + 4'h1;
                if (s.bitc == 4'h8) begin
                  next_s.bitc = 4'h0;
                  next_s.step = s.step + 2'h1;
                  if (s.nack || s.step == 2'h3 || (s.step == 2'h2 && !s.rd)) begin
                    next_s.st = MS_STOP;
                  end else if (s.step == 2'h0) begin
                    next_s.tx = s.addr;
                  end else if (s.step == 2'h1) begin
                    next_s.tx = s.rd ? {DEV_ADDR, 1'b1} : s.wdata;
                    next_s.st = s.rd ? MS_START : MS_BIT;
                  end else begin
                    next_s.tx = 8'hFF;
                  end
                end
              end
            endcase
          end
          MS_STOP: begin
            unique case (s.q)
              2'h0: next_s.sda_oe = 1'b1;
              2'h1: next_s.scl_oe = 1'b0;
              2'h2: next_s.sda_oe = 1'b0;
              2'h3: begin
                next_s.st = MS_IDLE;
                next_s.rsp_valid = 1'b1;
                next_s.rsp_err = s.nack;
                next_s.rsp_data = s.rd ? s.rx : 8'h00;
                if (!s.rd && !s.nack && s.addr == REG_POWER_MODE) begin
                  next_s.operate = s.wdata[OPERATE_BIT];
                end
              end
            endcase
          end
          default: next_s.st = MS_IDLE;
        endcase
      end
    end
    next_s.cmd_ready = next_s.ready && next_s.st == MS_IDLE;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link.scl_o_host = 1'b0;
  assign link.scl_oe_host = s.scl_oe;
  assign link.sda_o_host = 1'b0;
  assign link.sda_oe_host = s.sda_oe;
  assign cmd_ready = s.cmd_ready;
  assign rsp_valid = s.rsp_valid;
  assign rsp_data = s.rsp_data;
  assign rsp_err = s.rsp_err;
  assign int_seen = s.int_seen;

endmodule

// ==== mwu_link_monitor.sv ====
`timescale 1ns/10ps
module mwu_link_monitor (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Synchronous reset
  input wire logic scl, // Resolved clock wire
  input wire logic sda, // Resolved data wire
  input wire logic scl_o_host, // Host clock level
  input wire logic scl_oe_host, // Host clock enable
  input wire logic sda_oe_host, // Host data enable
  input wire logic sda_oe_dev, // Device data enable
  input wire logic int_pin // Interrupt pin
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [5:0] high_cnt;
  logic bus_idle;
  // Idle means the clock has stayed high far longer than any bit's high phase
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !scl) begin
      high_cnt <= 6'h00;
    end else if (high_cnt != 6'h3f) begin
      high_cnt <= high_cnt + 6'h01;
    end
  end
  assign bus_idle = (high_cnt >= 6'h28);

  property p_reset_quiet;
    $rose(rst_n) |-> !scl_oe_host && !sda_oe_host && !sda_oe_dev && !int_pin;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("bus or pin active out of reset");
  property p_open_drain;
    scl_oe_host |-> !scl_o_host;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("host drives clock high");
  property p_scl_low;
    $fell(scl) |=> !scl [*8];
  endproperty
  a_scl_low: assert property (p_scl_low) else $error("clock low phase too short");
  property p_scl_high;
    $rose(scl) |=> scl [*5];
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high phase too short");
  property p_start_hold;
    (scl && $fell(sda)) |=> scl [*5];
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start hold too short");
  property p_stop_setup;
    (scl && $rose(sda)) |-> $past(scl, 5);
  endproperty
  a_stop_setup: assert property (p_stop_setup) else $error("stop setup too short");
  property p_dev_steady;
    (scl && $past(scl)) |-> $stable(sda_oe_dev);
  endproperty
  a_dev_steady: assert property (p_dev_steady) else $error("device data moved with clock high");
  property p_dev_quiet;
    bus_idle |-> !sda_oe_dev;
  endproperty
  a_dev_quiet: assert property (p_dev_quiet) else $error("device holds idle bus");
  property p_latch_hold;
    (int_pin && bus_idle) |=> int_pin;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("interrupt dropped without read");
endmodule

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  import mwu_pkg::*;
  localparam int READY = 50;
  localparam int RATE = 10;
  localparam int TICK = RATE * 2; // Rate code 6 is half the top rate
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [7:0] cmd_reg = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_ready, rsp_valid, rsp_err, int_seen, outputs_valid;
  logic [7:0] rsp_data;
  logic sample_valid = 1'b0;
  logic [2:0][SAMPLE_W-1:0] sample_xyz = '0;
  logic [2:0][SAMPLE_W-1:0] base = '0;
  logic [2:0][SAMPLE_W-1:0] step = '0;
  int failures = 0;
  int num_checks = 0;

  mwu_link_if link ();
  mwu_device #(.READY_CYCLES(READY), .SETTLE_CYCLES(20), .RATE_TOP_CYCLES(RATE)) mwu_device_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .link(link), .sample_valid(sample_valid),
    .sample_xyz(sample_xyz), .outputs_valid(outputs_valid));
  mwu_host #(.READY_CYCLES(READY)) mwu_host_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .link(link), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
    .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_err(rsp_err), .int_seen(int_seen));
  mwu_link_monitor mwu_link_monitor_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .scl(link.scl), .sda(link.sda), .scl_o_host(link.scl_o_host),
    .scl_oe_host(link.scl_oe_host), .sda_oe_host(link.sda_oe_host), .sda_oe_dev(link.sda_oe_dev),
    .int_pin(link.int_pin));

  initial begin
    forever begin
      #50 ref_clk = ~ref_clk;
    end
  end
  // Each axis ramps by its step per clock; a zero step is a still sensor
  always @(posedge ref_clk) begin
    for (int a = 0; a < 3; a++) begin
      sample_xyz[a] <= rst_n ? sample_xyz[a] + step[a] : base[a];
    end
  end

  function automatic logic moves(input int per_clk, input int thr);
    return per_clk * TICK > thr * (1024 / THR_PER_G);
  endfunction

  task automatic finish_test;
    $display("Checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic e);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (cmd_ready !== 1'b1) begin
      if (++n > 2000) begin
        failures++;
        finish_test();
      end
      @(negedge ref_clk);
    end
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_reg <= a;
    cmd_wdata <= d;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    n = 0;
    @(negedge ref_clk);
    while (rsp_valid !== 1'b1) begin
      if (++n > 2000) begin
        failures++;
        finish_test();
      end
      @(negedge ref_clk);
    end
    q = rsp_data;
    e = rsp_err;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic exp_e);
    logic [7:0] q;
    logic e;
    xfer(1'b0, a, d, q, e);
    chk("write error", {7'h00, exp_e}, {7'h00, e});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic e;
    xfer(1'b1, a, 8'h00, q, e);
    chk("read error", 8'h00, {7'h00, e});
    chk("read data", exp, q);
  endtask

  // Bounded wait for a level: sel 0 watches the interrupt, 1 the settled flag
  task automatic wait_lvl(input logic sel, input logic lvl, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      if (++n > lim) begin
        failures++;
        finish_test();
      end
    end while ((sel ? outputs_valid : int_seen) !== lvl);
    chk("level", {7'h00, lvl}, {7'h00, sel ? outputs_valid : int_seen});
  endtask

  task automatic hold_int(input logic lvl, input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("int_seen", {7'h00, lvl}, {7'h00, int_seen});
  endtask

  initial begin
    logic [7:0] r;
    r = 8'($urandom(71));
    for (int a = 0; a < 3; a++) begin
      base[a] = SAMPLE_W'($urandom());
    end
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    sample_valid <= 1'b1;
    rd(REG_POWER_MODE, REG_RESET_VAL);
    rd(REG_PIN_CONFIG, REG_RESET_VAL);
    rd(REG_THRESHOLD, REG_RESET_VAL);
    rd(8'h55, READ_UNMAPPED);
    r = 8'($urandom());
    wr(REG_THRESHOLD, r, 1'b0);
    rd(REG_THRESHOLD, r);
    wr(REG_POWER_MODE, 8'h42, 1'b0);
    chk("outputs_valid", 8'h00, {7'h00, outputs_valid});
    wr(REG_RATE_CTRL, 8'h06, 1'b0);
    wr(REG_DIR_MASK, 8'h30, 1'b0);
    wr(REG_PERSIST, 8'h05, 1'b0);
    wr(REG_THRESHOLD, 8'h08, 1'b0);
    wr(REG_PIN_CONFIG, 8'h30, 1'b0);
    rd(REG_PIN_CONFIG, 8'h30);
    rd(REG_THRESHOLD, 8'h08);
    hold_int(1'b0, 20);
    wr(REG_POWER_MODE, 8'hC2, 1'b0);
    wait_lvl(1'b1, 1'b1, 200);
    wr(REG_THRESHOLD, 8'h10, 1'b1);
    hold_int(1'b0, 10 * TICK);
    step <= {12'd0, 12'd40, 12'd0};
    hold_int(1'b0, 15 * TICK);
    step <= {12'd25, 12'd0, 12'd0};
    hold_int(moves(25, 8), 15 * TICK);
    step <= {12'd26, 12'd0, 12'd0};
    hold_int(1'b0, 3 * TICK);
    wait_lvl(1'b0, moves(26, 8), 12 * TICK);
    step <= '0;
    hold_int(1'b1, 10 * TICK);
    rd(REG_INT_RELEASE, 8'h01);
    wait_lvl(1'b0, 1'b0, 20);
    hold_int(1'b0, 10 * TICK);
    finish_test();
  end
endmodule
